// [core/sbpbr_pkg.sv]
// Constants for the serial bus PHY base register bank
package sbpbr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_NODE_IDENTITY = 4'h0;
    localparam logic [3:0] IDX_RESET_GAP = 4'h1;
    localparam logic [3:0] IDX_PORT_CAPABILITY = 4'h2;
    localparam logic [3:0] IDX_SPEED_DELAY = 4'h3;
    localparam logic [3:0] IDX_LINK_POWER = 4'h4;
    localparam logic [3:0] IDX_EVENT_FEATURE = 4'h5;
    localparam logic [3:0] IDX_SPARE_SIX = 4'h6;
    localparam logic [3:0] IDX_PAGE_PORT = 4'h7;
    localparam logic [3:0] IDX_PAGED_FIRST = 4'h8;
    localparam int BYTE_ADDR_SHIFT = 2;
    localparam int REG_COUNT = 16;

    // Field positions inside the 8-bit data
    localparam int NODE_NUMBER_LSB = 2;
    localparam int ROOT_BIT = 1;
    localparam int CABLE_POWER_BIT = 0;
    localparam int ROOT_HOLDOFF_BIT = 7;
    localparam int LONG_RESET_BIT = 6;
    localparam int GAP_LSB = 0;
    localparam int PAGE_LSB = 5;
    localparam int PORT_LSB = 0;

    // Constant capability codes
    localparam logic [2:0] EXTENDED_CODE = 3'h7;
    localparam logic [3:0] PORT_TOTAL = 4'h2;
    localparam logic [2:0] SPEED_S400 = 3'h2;
    localparam logic [3:0] REPEATER_DELAY = 4'h0;

    // Values after system reset
    localparam logic [5:0] GAP_DEFAULT = 6'h3F;
    localparam logic [2:0] PAGE_RESET = 3'h0;
    localparam logic [3:0] PORT_RESET = 4'h0;
    localparam logic [5:0] NODE_RESET = 6'h00;

    // Pages whose registers are all reserved
    localparam logic [2:0] PAGE_RSVD_LO = 3'h2;
    localparam logic [2:0] PAGE_RSVD_HI = 3'h6;

    // Long bus reset timing
    localparam int LONG_RESET_US = 166;
    localparam int CLK_KHZ = 10000;
    localparam int LONG_RESET_CYC = (LONG_RESET_US * CLK_KHZ) / 1000;
    localparam int CNT_W = 12;

    // Long bus reset sequencer states
    typedef enum logic [1:0] {
        LR_IDLE = 2'b00,
        LR_ACTIVE = 2'b01
    } sbpbr_lr_t;
endpackage

// [core/sbpbr_regs.sv]
// Base register bank of a two-port serial bus PHY, reached over APB
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module sbpbr_regs #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pin from the cable
    input wire logic cable_power_ok,
    // Events from the PHY core, same clock
    input wire logic bus_reset_evt,
    input wire logic tree_root_evt,
    input wire logic self_id_done,
    input wire logic [5:0] self_id_node,
    input wire logic cfg_gap_evt,
    input wire logic [5:0] cfg_gap_value,
    input wire logic xfer_busy,
    // Controls to the PHY core
    output logic [5:0] gap_count,
    output logic root_holdoff,
    output logic long_reset_active,
    output logic [3:0] port_choice,
    // Unsolicited register 0 status
    output logic status_push,
    output logic [7:0] status_data
);

    typedef struct packed {
        logic cps_meta;
        logic cps_sync;
        logic [5:0] node_number;
        logic node_valid;
        logic root;
        logic root_holdoff;
        logic long_req;
        logic [5:0] gap;
        logic gap_stale;
        logic [2:0] page;
        logic [3:0] port;
        sbpbr_pkg::sbpbr_lr_t lr_state;
        logic [sbpbr_pkg::CNT_W-1:0] lr_cnt;
        logic armed;
        logic [7:0] rdata;
        logic push;
        logic [7:0] push_data;
    } sbpbr_state_t;

    localparam sbpbr_state_t ST_RESET = '{
        cps_meta: 1'b0,
        cps_sync: 1'b0,
        node_number: sbpbr_pkg::NODE_RESET,
        node_valid: 1'b0,
        root: 1'b0,
        root_holdoff: 1'b0,
        long_req: 1'b0,
        gap: sbpbr_pkg::GAP_DEFAULT,
        gap_stale: 1'b0,
        page: sbpbr_pkg::PAGE_RESET,
        port: sbpbr_pkg::PORT_RESET,
        lr_state: sbpbr_pkg::LR_IDLE,
        lr_cnt: '0,
        armed: 1'b0,
        rdata: 8'h00,
        push: 1'b0,
        push_data: 8'h00
    };

    localparam logic [sbpbr_pkg::CNT_W-1:0] LR_LAST =
        sbpbr_pkg::CNT_W'(sbpbr_pkg::LONG_RESET_CYC - 1);

    // Parameter sanity
    generate
        if (ADDR_W < 7) begin : g_bad_addr
            $error("ADDR_W must leave a bit above the sixteen word registers");
        end
        if (sbpbr_pkg::LONG_RESET_CYC >= (1 << sbpbr_pkg::CNT_W)) begin : g_bad_cnt
            $error("Long reset counter too narrow");
        end
    endgenerate

    sbpbr_state_t st_reg;
    sbpbr_state_t st_next;

    // Address decode
    logic [3:0] idx;
    logic addr_ok;
    logic access_done;
    logic wr_done;
    logic wr_byte;
    logic lr_start;
    logic any_bus_reset;
    logic gap_write;
    logic [7:0] rd_mux;

    assign idx = paddr[sbpbr_pkg::BYTE_ADDR_SHIFT +: 4];
    // Only the sixteen aligned words are mapped
    assign addr_ok = (paddr[1:0] == 2'b00) &&
        (paddr[ADDR_W-1:sbpbr_pkg::BYTE_ADDR_SHIFT+4] == '0);

    // Answer is held until the read data flop has caught the address
    assign pready = ce && psel && penable && st_reg.armed;
    assign pslverr = pready && !addr_ok;
    assign access_done = pready;
    assign wr_done = access_done && pwrite && addr_ok;
    assign wr_byte = wr_done && pstrb[0];
    assign prdata = {24'h00_0000, st_reg.rdata};

    // Long reset begins only when no packet is on the wire
    assign lr_start = st_reg.long_req && !xfer_busy &&
        (st_reg.lr_state == sbpbr_pkg::LR_IDLE);
    assign any_bus_reset = bus_reset_evt || lr_start;
    assign gap_write = wr_byte && (idx == sbpbr_pkg::IDX_RESET_GAP);

    // Read data mux; base fields never look at the page
    always_comb begin
        rd_mux = 8'h00;
        case (idx)
            sbpbr_pkg::IDX_NODE_IDENTITY: begin
                rd_mux[sbpbr_pkg::NODE_NUMBER_LSB +: 6] = st_reg.node_number;
                rd_mux[sbpbr_pkg::ROOT_BIT] = st_reg.root;
                rd_mux[sbpbr_pkg::CABLE_POWER_BIT] = st_reg.cps_sync;
            end
            sbpbr_pkg::IDX_RESET_GAP: begin
                rd_mux[sbpbr_pkg::ROOT_HOLDOFF_BIT] = st_reg.root_holdoff;
                rd_mux[sbpbr_pkg::LONG_RESET_BIT] = st_reg.long_req;
                rd_mux[sbpbr_pkg::GAP_LSB +: 6] = st_reg.gap;
            end
            sbpbr_pkg::IDX_PORT_CAPABILITY: begin
                rd_mux = {sbpbr_pkg::EXTENDED_CODE, 1'b0, sbpbr_pkg::PORT_TOTAL};
            end
            sbpbr_pkg::IDX_SPEED_DELAY: begin
                rd_mux = {sbpbr_pkg::SPEED_S400, 1'b0, sbpbr_pkg::REPEATER_DELAY};
            end
            sbpbr_pkg::IDX_PAGE_PORT: begin
                rd_mux[sbpbr_pkg::PAGE_LSB +: 3] = st_reg.page;
                rd_mux[sbpbr_pkg::PORT_LSB +: 4] = st_reg.port;
            end
            default: begin
                // Registers 4 to 6 and every paged slot read zero here
                rd_mux = 8'h00;
            end
        endcase
        if (!addr_ok) begin
            rd_mux = 8'h00;
        end
    end

    // Next state of the whole bank
    always_comb begin
        st_next = st_reg;
        // Cable power sense crosses in through two flops
        st_next.cps_meta = cable_power_ok;
        st_next.cps_sync = st_reg.cps_meta;

        // Read data caught during setup, stable through access
        if (psel) begin
            st_next.rdata = rd_mux;
        end
        st_next.armed = psel && !access_done;

        // Node number and unsolicited status
        st_next.push = 1'b0;
        if (bus_reset_evt || lr_start) begin
            st_next.node_valid = 1'b0;
        end
        if (self_id_done) begin
            st_next.node_number = self_id_node;
            st_next.node_valid = 1'b1;
            st_next.push = 1'b1;
            st_next.push_data = {self_id_node, st_reg.root, st_reg.cps_sync};
        end

        // Root flag; tree-ID set wins a same-cycle reset
        if (any_bus_reset) begin
            st_next.root = 1'b0;
        end
        if (tree_root_evt) begin
            st_next.root = 1'b1;
        end

        // Long reset request, cleared by any bus reset
        if (any_bus_reset) begin
            st_next.long_req = 1'b0;
        end

        // Gap count staleness across bus resets
        if (any_bus_reset) begin
            if (st_reg.gap_stale) begin
                st_next.gap = sbpbr_pkg::GAP_DEFAULT;
            end
            st_next.gap_stale = 1'b1;
        end
        if (cfg_gap_evt) begin
            st_next.gap = cfg_gap_value;
            st_next.gap_stale = 1'b0;
        end

        // Register writes take effect at the accepting edge
        if (gap_write) begin
            st_next.root_holdoff = pwdata[sbpbr_pkg::ROOT_HOLDOFF_BIT];
            st_next.gap = pwdata[sbpbr_pkg::GAP_LSB +: 6];
            st_next.gap_stale = 1'b0;
            if (pwdata[sbpbr_pkg::LONG_RESET_BIT]) begin
                st_next.long_req = 1'b1;
            end
        end
        if (wr_byte && (idx == sbpbr_pkg::IDX_PAGE_PORT)) begin
            st_next.page = pwdata[sbpbr_pkg::PAGE_LSB +: 3];
            st_next.port = pwdata[sbpbr_pkg::PORT_LSB +: 4];
        end

        // Long bus reset sequencer
        case (st_reg.lr_state)
            sbpbr_pkg::LR_IDLE: begin
                if (lr_start) begin
                    st_next.lr_state = sbpbr_pkg::LR_ACTIVE;
                    st_next.lr_cnt = LR_LAST;
                end
            end
            sbpbr_pkg::LR_ACTIVE: begin
                if (st_reg.lr_cnt == '0) begin
                    st_next.lr_state = sbpbr_pkg::LR_IDLE;
                end else begin
                    st_next.lr_cnt = st_reg.lr_cnt - 1'b1;
                end
            end
            default: begin
                st_next.lr_state = sbpbr_pkg::LR_IDLE;
            end
        endcase
    end

    // State register; enable low freezes everything
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs to the core
    assign gap_count = st_reg.gap;
    assign root_holdoff = st_reg.root_holdoff;
    assign long_reset_active = (st_reg.lr_state == sbpbr_pkg::LR_ACTIVE);
    assign port_choice = st_reg.port;
    assign status_push = st_reg.push;
    assign status_data = st_reg.push_data;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // Helper: length of each long reset in enabled cycles
    logic [sbpbr_pkg::CNT_W:0] h_lr_len;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            h_lr_len <= '0;
        end else if (ce) begin
            h_lr_len <= long_reset_active ? h_lr_len + 1'b1 : '0;
        end
    end

    sequence seq_rd_done(logic [3:0] i);
        pready && !pwrite && addr_ok && (idx == i);
    endsequence
    sequence seq_wr_done(logic [3:0] i);
        wr_byte && (idx == i);
    endsequence
    sequence seq_two_stale_resets;
        ce && any_bus_reset && st_reg.gap_stale && !cfg_gap_evt && !gap_write;
    endsequence
    sequence seq_setup;
        ce && psel && !penable;
    endsequence

    a_rsvd_pages: assert property (
        pready && !pwrite && addr_ok && idx[3] && (st_reg.page >= sbpbr_pkg::PAGE_RSVD_LO) &&
        (st_reg.page <= sbpbr_pkg::PAGE_RSVD_HI) |-> prdata == 32'h0000_0000)
        else $error("Reserved page read not zero");
    a_port_caps: assert property (seq_rd_done(sbpbr_pkg::IDX_PORT_CAPABILITY) |->
        prdata == 32'h0000_00E2)
        else $error("Port capability code wrong");
    a_speed_code: assert property (seq_rd_done(sbpbr_pkg::IDX_SPEED_DELAY) |->
        prdata == 32'h0000_0040)
        else $error("Speed and delay code wrong");
    a_root_clear: assert property (ce && bus_reset_evt && !tree_root_evt |=> !st_reg.root)
        else $error("Root flag kept over bus reset");
    a_cps_mirror: assert property ((ce && cable_power_ok)[*3] |=>
        st_reg.cps_sync)
        else $error("Cable power flag does not follow input");
    a_busy_waits: assert property ($rose(long_reset_active) |-> $past(!xfer_busy))
        else $error("Long reset started during transfer");
    a_long_len: assert property ($fell(long_reset_active) |->
        h_lr_len == (sbpbr_pkg::CNT_W+1)'(sbpbr_pkg::LONG_RESET_CYC))
        else $error("Long reset length wrong");
    a_req_clear: assert property (ce && bus_reset_evt && !gap_write |=> !st_reg.long_req)
        else $error("Long reset request survived bus reset");
    a_gap_default: assert property (seq_two_stale_resets |=>
        gap_count == sbpbr_pkg::GAP_DEFAULT)
        else $error("Gap not restored after two stale resets");
    a_gap_write: assert property (seq_wr_done(sbpbr_pkg::IDX_RESET_GAP) |=>
        gap_count == $past(pwdata[5:0]))
        else $error("Gap write lost");
    a_page_write: assert property (seq_wr_done(sbpbr_pkg::IDX_PAGE_PORT) |=>
        st_reg.page == $past(pwdata[7:5]))
        else $error("Page select write lost");
    a_status_push: assert property (ce && self_id_done |=>
        status_push && (status_data[7:2] == $past(self_id_node)) ##1 (!status_push || $past(!ce || self_id_done)))
        else $error("Self-ID status not pushed once");
    a_holdoff_keep: assert property (ce && bus_reset_evt && !gap_write |=>
        $stable(root_holdoff))
        else $error("Root holdoff changed by bus reset");

    // Reserved base words and bad addresses hand back zero data
    a_rsvd_base: assert property (
        pready && !pwrite && addr_ok && (idx >= sbpbr_pkg::IDX_LINK_POWER) &&
        (idx <= sbpbr_pkg::IDX_SPARE_SIX) |-> prdata == 32'h0000_0000)
        else $error("Reserved base register read not zero");
    a_unmapped_zero: assert property (pready && !addr_ok |->
        pslverr && (prdata == 32'h0000_0000))
        else $error("Unmapped access not refused");
    a_cfg_gap: assert property (ce && cfg_gap_evt && !gap_write |=>
        gap_count == $past(cfg_gap_value))
        else $error("Config packet gap lost");
    a_holdoff_write: assert property (seq_wr_done(sbpbr_pkg::IDX_RESET_GAP) |=>
        root_holdoff == $past(pwdata[sbpbr_pkg::ROOT_HOLDOFF_BIT]))
        else $error("Root holdoff write lost");
    a_root_set: assert property (ce && tree_root_evt |=> st_reg.root)
        else $error("Root flag not set by tree-ID");
    // Counter stays below the full length while the reset is driven
    a_long_bound: assert property (long_reset_active |->
        h_lr_len < (sbpbr_pkg::CNT_W+1)'(sbpbr_pkg::LONG_RESET_CYC))
        else $error("Long reset ran past its length");
    // Zero wait states: an enabled setup is answered in the first access cycle
    a_zero_wait: assert property (seq_setup ##1 (ce && psel && penable) |-> pready)
        else $error("Access phase not answered");

endmodule

// [bench/sbpbr_link_model.sv]
// Link layer side model: APB master issuing PHY register transfers
`timescale 1ns/100ps
module sbpbr_link_model (
    // Clock
    input wire logic core_clk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
    end

    // One whole byte per word, held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [7:0] q, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        // Values read right after an edge are those that stood before it
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not look like the last data
        pwdata <= ~pwdata;
    endtask
endmodule

// [bench/test_serial_bus_phy_base_registers.sv]
// Self-checking bench for the PHY base register bank
`timescale 1ns/100ps
module test_serial_bus_phy_base_registers;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic cable_power_ok = 1'b1;
    logic bus_reset_evt = 1'b0;
    logic tree_root_evt = 1'b0;
    logic self_id_done = 1'b0;
    logic [5:0] self_id_node = 6'h00;
    logic cfg_gap_evt = 1'b0;
    logic [5:0] cfg_gap_value = 6'h00;
    logic xfer_busy = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [5:0] gap_count;
    logic root_holdoff, long_reset_active, status_push;
    logic [3:0] port_choice;
    logic [7:0] status_data, q;
    logic e;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    // 100 ns clock
    always #50 core_clk = ~core_clk;

    sbpbr_regs #(.ADDR_W(8)) sbpbr_regs_inst (.core_clk(core_clk), .arst_n(arst_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cable_power_ok(cable_power_ok),
        .bus_reset_evt(bus_reset_evt), .tree_root_evt(tree_root_evt), .self_id_done(self_id_done),
        .self_id_node(self_id_node), .cfg_gap_evt(cfg_gap_evt), .cfg_gap_value(cfg_gap_value),
        .xfer_busy(xfer_busy), .gap_count(gap_count), .root_holdoff(root_holdoff),
        .long_reset_active(long_reset_active), .port_choice(port_choice),
        .status_push(status_push), .status_data(status_data));

    sbpbr_link_model sbpbr_link_model_inst (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well above the long reset plus traffic
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [7:0] ba(input logic [3:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input string nm);
        sbpbr_link_model_inst.xfer(1'b0, ba(idx), 8'h00, 4'hF, q, e);
        chk(nm, exp, q);
        chk("pslverr", 8'h00, {7'h00, e});
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        sbpbr_link_model_inst.xfer(1'b1, ba(idx), d, 4'hF, q, e);
    endtask

    // One-cycle core event: 0 tree root, 1 self-ID, 2 bus reset, 3 config gap
    task automatic pulse(input int k);
        @(posedge core_clk);
        tree_root_evt <= (k == 0);
        self_id_done <= (k == 1);
        bus_reset_evt <= (k == 2);
        cfg_gap_evt <= (k == 3);
        @(posedge core_clk);
        tree_root_evt <= 1'b0;
        self_id_done <= 1'b0;
        bus_reset_evt <= 1'b0;
        cfg_gap_evt <= 1'b0;
    endtask

    task automatic t_reset_values();
        chk("gap_count", 8'h3F, {2'b00, gap_count});
        rd(4'h1, 8'h3F, "reg1");
        rd(4'h2, {sbpbr_pkg::EXTENDED_CODE, 1'b0, sbpbr_pkg::PORT_TOTAL}, "reg2");
        rd(4'h3, {sbpbr_pkg::SPEED_S400, 1'b0, sbpbr_pkg::REPEATER_DELAY}, "reg3");
        rd(4'h6, 8'h00, "reg6");
        rd(4'h7, 8'h00, "reg7");
        $display("test reset_values done");
    endtask

    task automatic t_cable_power();
        @(posedge core_clk) cable_power_ok <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(4'h0, 8'h00, "reg0 low power");
        @(posedge core_clk) cable_power_ok <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(4'h0, 8'h01, "reg0 power ok");
        $display("test cable_power done");
    endtask

    task automatic t_self_id_root();
        pulse(0);
        @(posedge core_clk) self_id_node <= 6'h15;
        pulse(1);
        @(negedge core_clk);
        chk("status_push", 8'h01, {7'h00, status_push});
        chk("status_data", 8'h57, status_data);
        @(negedge core_clk);
        chk("status_push end", 8'h00, {7'h00, status_push});
        rd(4'h0, 8'h57, "reg0 root");
        pulse(2);
        rd(4'h0, 8'h55, "reg0 after bus reset");
        $display("test self_id_root done");
    endtask

    task automatic t_gap();
        wr(4'h1, 8'h8A);
        @(negedge core_clk);
        chk("gap_count write", 8'h0A, {2'b00, gap_count});
        chk("root_holdoff", 8'h01, {7'h00, root_holdoff});
        pulse(2);
        rd(4'h1, 8'h8A, "reg1 one reset");
        pulse(2);
        rd(4'h1, 8'hBF, "reg1 two resets");
        @(posedge core_clk) cfg_gap_value <= 6'h11;
        pulse(3);
        pulse(2);
        rd(4'h1, 8'h91, "reg1 config gap");
        $display("test gap done");
    endtask

    task automatic t_pages();
        wr(4'h7, 8'h65);
        rd(4'h7, 8'h65, "reg7");
        chk("port_choice", 8'h05, {4'h0, port_choice});
        rd(4'h9, 8'h00, "paged reserved");
        rd(4'h2, 8'hE2, "reg2 paged");
        sbpbr_link_model_inst.xfer(1'b0, 8'h40, 8'h00, 4'hF, q, e);
        chk("unmapped err", 8'h01, {7'h00, e});
        chk("unmapped data", 8'h00, q);
        sbpbr_link_model_inst.xfer(1'b1, ba(4'h7), 8'h00, 4'hE, q, e);
        rd(4'h7, 8'h65, "reg7 strobe off");
        wr(4'h7, 8'h00);
        $display("test pages done");
    endtask

    task automatic t_long_reset();
        int n;
        n = 0;
        @(posedge core_clk) xfer_busy <= 1'b1;
        wr(4'h1, 8'h51);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        chk("held while busy", 8'h00, {7'h00, long_reset_active});
        rd(4'h1, 8'h51, "reg1 request");
        @(posedge core_clk) xfer_busy <= 1'b0;
        while (long_reset_active !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (long_reset_active === 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        chk("long reset cycles lo", sbpbr_pkg::LONG_RESET_CYC[7:0], n[7:0]);
        chk("long reset cycles hi", sbpbr_pkg::LONG_RESET_CYC[15:8], n[15:8]);
        rd(4'h1, 8'h11, "reg1 request cleared");
        $display("test long_reset done");
    endtask

    // Enable low must freeze the bank against core events
    task automatic t_clock_enable();
        @(posedge core_clk) ce <= 1'b0;
        pulse(0);
        @(posedge core_clk) ce <= 1'b1;
        rd(4'h0, 8'h55, "reg0 event while frozen");
        $display("test clock_enable done");
    endtask

    // System reset in mid-run clears the writable controls
    task automatic t_sys_reset();
        @(posedge core_clk) xfer_busy <= 1'b1;
        wr(4'h1, 8'hC5);
        rd(4'h1, 8'hC5, "reg1 before system reset");
        @(posedge core_clk) arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk) xfer_busy <= 1'b0;
        rd(4'h1, 8'h3F, "reg1 after system reset");
        @(negedge core_clk);
        chk("long reset after system reset", 8'h00, {7'h00, long_reset_active});
        chk("root_holdoff after system reset", 8'h00, {7'h00, root_holdoff});
        $display("test sys_reset done");
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset_values();
        t_cable_power();
        t_self_id_root();
        t_clock_enable();
        t_gap();
        t_pages();
        t_long_reset();
        t_sys_reset();
        final_report();
    end
endmodule
